// file: spc_defines.vh
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// Register addresses
`define SPC_ADDR_CFG        13'h0000
`define SPC_ADDR_VARIANT    13'h0003
`define SPC_ADDR_RB_SEL     13'h0004
`define SPC_ADDR_PD_SYNC    13'h0230
`define SPC_ADDR_RSVD_SYS   13'h0231
`define SPC_ADDR_UPDATE     13'h0232

// Reset values
`define SPC_CFG_RESET       8'h18
`define SPC_RB_SEL_RESET    8'h00
`define SPC_PD_SYNC_RESET   8'h00
`define SPC_RSVD_SYS_RESET  8'h00
`define SPC_UPDATE_RESET    8'h00
// Arbitrary identifier value
`define SPC_VARIANT_ID      8'h5A

// Configuration register fields
`define SPC_CFG_OUT_SEL     0
`define SPC_CFG_LSB_FIRST   1
`define SPC_CFG_SOFT_RST    2
`define SPC_CFG_LONG_INSTR  3

// Other fields
`define SPC_RB_SEL_BIT      0
`define SPC_UPDATE_BIT      0

// Instruction word layout
`define SPC_INSTR_BITS      16
`define SPC_INSTR_RW        15
`define SPC_INSTR_LEN_HI    14
`define SPC_INSTR_LEN_LO    13
`define SPC_INSTR_ADDR_HI   12
`define SPC_LEN_STREAM      2'h3

// Bit counts
`define SPC_INSTR_LAST_BIT  4'hf
`define SPC_BYTE_LAST_BIT   4'h7

`endif

// file: spc_serial_port_config_regs.v
`timescale 1ns/1ps
`include "spc_defines.vh"
`default_nettype none

module spc_serial_port_config_regs
(
    // Clock and reset
    input  wire       clk_i,
    input  wire       resetn_i,
    // Serial control port
    input  wire       sclk_i,
    input  wire       csn_i,
    input  wire       sdio_in_i,
    output wire       sdio_out_o,
    output wire       sdio_oe_o,
    output wire       dedicated_read_output_pin_o,
    output wire       dedicated_read_output_pin_oe_o,
    // Active settings
    output wire [7:0] pd_sync_active_o,
    output wire       soft_reset_o
);

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_INSTR = 4'b0010;
    localparam [3:0] ST_DATA  = 4'b0100;
    localparam [3:0] ST_DONE  = 4'b1000;

    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg         sclk_d_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [15:0] instr_sh_reg;
    reg  [7:0]  data_sh_reg;
    reg         rd_mode_reg;
    reg  [1:0]  len_reg;
    reg  [1:0]  byte_cnt_reg;
    reg  [12:0] addr_reg;
    reg  [7:0]  rd_byte_reg;
    reg         sdio_out_reg;
    reg         sdio_oe_reg;
    reg         sdo_out_reg;
    reg         sdo_oe_reg;
    reg  [7:0]  cfg_reg;
    reg  [7:0]  rb_sel_reg;
    reg  [7:0]  pd_buf_reg;
    reg  [7:0]  pd_act_reg;
    reg  [7:0]  update_reg;

    wire        sclk_rise;
    wire        sclk_fall;
    wire        lsb_first;
    wire        out_sel;
    wire        soft_rst;
    wire [15:0] instr_nx;
    wire [7:0]  data_nx;
    wire [12:0] addr_step;
    wire [12:0] first_addr;
    wire        instr_done;
    wire        byte_done;
    wire        wr_strobe;
    wire        last_byte;
    reg  [7:0]  rd_mux;
    reg  [12:0] rd_addr;

    assign sclk_rise  = sclk_i & ~sclk_d_reg;
    assign sclk_fall  = ~sclk_i & sclk_d_reg;
    // Only the low nibble is decoded; the mirror makes either order land here
    assign out_sel    = cfg_reg[`SPC_CFG_OUT_SEL];
    assign lsb_first  = cfg_reg[`SPC_CFG_LSB_FIRST];
    assign soft_rst   = cfg_reg[`SPC_CFG_SOFT_RST];

    // Shift direction follows bit order; words end up in normal order
    assign instr_nx   = lsb_first ? {sdio_in_i, instr_sh_reg[15:1]}
                                  : {instr_sh_reg[14:0], sdio_in_i};
    assign data_nx    = lsb_first ? {sdio_in_i, data_sh_reg[7:1]}
                                  : {data_sh_reg[6:0], sdio_in_i};
    assign addr_step  = lsb_first ? addr_reg + 13'h0001
                                  : addr_reg - 13'h0001;
    assign first_addr = instr_nx[`SPC_INSTR_ADDR_HI:0];

    // Instruction length is fixed at 16 bits whatever the length bit says
    assign instr_done = state_reg[1] & sclk_rise & (bit_cnt_reg == `SPC_INSTR_LAST_BIT);
    assign byte_done  = state_reg[2] & sclk_rise & (bit_cnt_reg == `SPC_BYTE_LAST_BIT);
    assign wr_strobe  = byte_done & ~rd_mode_reg;
    assign last_byte  = (len_reg != `SPC_LEN_STREAM) && (byte_cnt_reg == len_reg);

    // Address presented to the read mux for the next byte
    always @*
    begin
        if (instr_done)
            rd_addr = first_addr;
        else
            rd_addr = addr_step;
    end

    always @*
    begin
        case (rd_addr)
            `SPC_ADDR_CFG:      rd_mux = cfg_reg;
            `SPC_ADDR_VARIANT:  rd_mux = `SPC_VARIANT_ID;
            `SPC_ADDR_RB_SEL:   rd_mux = rb_sel_reg;
            `SPC_ADDR_PD_SYNC:  rd_mux = rb_sel_reg[`SPC_RB_SEL_BIT] ? pd_act_reg
                                                                     : pd_buf_reg;
            `SPC_ADDR_RSVD_SYS: rd_mux = `SPC_RSVD_SYS_RESET;
            `SPC_ADDR_UPDATE:   rd_mux = update_reg;
            default:            rd_mux = 8'h00;
        endcase
    end

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (!csn_i)
                    state_next = ST_INSTR;
            end
            ST_INSTR:
            begin
                if (instr_done)
                    state_next = ST_DATA;
            end
            ST_DATA:
            begin
                if (byte_done && last_byte)
                    state_next = ST_DONE;
            end
            ST_DONE:
            begin
                state_next = ST_DONE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // Chip select high aborts any frame
        if (csn_i)
            state_next = ST_IDLE;
    end

    // Serial framing
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg    <= ST_IDLE;
            sclk_d_reg   <= 1'b0;
            bit_cnt_reg  <= 4'h0;
            instr_sh_reg <= 16'h0000;
            data_sh_reg  <= 8'h00;
            rd_mode_reg  <= 1'b0;
            len_reg      <= 2'h0;
            byte_cnt_reg <= 2'h0;
            addr_reg     <= 13'h0000;
            rd_byte_reg  <= 8'h00;
        end
        else
        begin
            state_reg  <= state_next;
            sclk_d_reg <= sclk_i;
            if (csn_i)
            begin
                bit_cnt_reg  <= 4'h0;
                byte_cnt_reg <= 2'h0;
            end
            else if (state_reg[1] && sclk_rise)
            begin
                instr_sh_reg <= instr_nx;
                bit_cnt_reg  <= instr_done ? 4'h0 : bit_cnt_reg + 4'h1;
                if (instr_done)
                begin
                    rd_mode_reg <= instr_nx[`SPC_INSTR_RW];
                    len_reg     <= instr_nx[`SPC_INSTR_LEN_HI:`SPC_INSTR_LEN_LO];
                    addr_reg    <= first_addr;
                    rd_byte_reg <= rd_mux;
                end
            end
            else if (state_reg[2] && sclk_rise)
            begin
                data_sh_reg <= data_nx;
                bit_cnt_reg <= byte_done ? 4'h0 : bit_cnt_reg + 4'h1;
                if (byte_done)
                begin
                    addr_reg     <= addr_step;
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    rd_byte_reg  <= rd_mux;
                end
            end
        end
    end

    // Read data pins; bits change on the falling edge so the host samples stable data
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sdio_out_reg <= 1'b0;
            sdio_oe_reg  <= 1'b0;
            sdo_out_reg  <= 1'b0;
            sdo_oe_reg   <= 1'b0;
        end
        else if (csn_i || !state_reg[2] || !rd_mode_reg)
        begin
            sdio_oe_reg <= 1'b0;
            sdo_oe_reg  <= 1'b0;
        end
        else if (sclk_fall)
        begin
            sdio_out_reg <= lsb_first ? rd_byte_reg[bit_cnt_reg[2:0]]
                                      : rd_byte_reg[3'h7 - bit_cnt_reg[2:0]];
            sdo_out_reg  <= lsb_first ? rd_byte_reg[bit_cnt_reg[2:0]]
                                      : rd_byte_reg[3'h7 - bit_cnt_reg[2:0]];
            sdio_oe_reg  <= ~out_sel;
            sdo_oe_reg   <= out_sel;
        end
    end

    // Register bank
    always @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_reg    <= `SPC_CFG_RESET;
            rb_sel_reg <= `SPC_RB_SEL_RESET;
            pd_buf_reg <= `SPC_PD_SYNC_RESET;
            pd_act_reg <= `SPC_PD_SYNC_RESET;
            update_reg <= `SPC_UPDATE_RESET;
        end
        else
        begin
            if (wr_strobe && addr_reg == `SPC_ADDR_CFG)
                cfg_reg <= data_nx;
            if (soft_rst)
            begin
                // Held while the bit stays set; the host must clear it
                rb_sel_reg <= `SPC_RB_SEL_RESET;
                pd_buf_reg <= `SPC_PD_SYNC_RESET;
                pd_act_reg <= `SPC_PD_SYNC_RESET;
                update_reg <= `SPC_UPDATE_RESET;
            end
            else if (update_reg[`SPC_UPDATE_BIT])
            begin
                // One-cycle copy so all settings change together
                pd_act_reg <= pd_buf_reg;
                update_reg <= `SPC_UPDATE_RESET;
            end
            else if (wr_strobe)
            begin
                // Identifier and reserved addresses fall through untouched
                case (addr_reg)
                    `SPC_ADDR_RB_SEL:  rb_sel_reg <= {7'h00, data_nx[`SPC_RB_SEL_BIT]};
                    `SPC_ADDR_PD_SYNC: pd_buf_reg <= data_nx;
                    `SPC_ADDR_UPDATE:  update_reg <= {7'h00, data_nx[`SPC_UPDATE_BIT]};
                    default:           update_reg <= update_reg;
                endcase
            end
        end
    end

    assign sdio_out_o                     = sdio_out_reg;
    assign sdio_oe_o                      = sdio_oe_reg;
    assign dedicated_read_output_pin_o    = sdo_out_reg;
    assign dedicated_read_output_pin_oe_o = sdo_oe_reg;
    assign pd_sync_active_o               = pd_act_reg;
    assign soft_reset_o                   = cfg_reg[`SPC_CFG_SOFT_RST];

endmodule // spc_serial_port_config_regs

`default_nettype wire

// file: spc_serial_port_config_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spc_serial_port_config_regs_checker
(
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       resetn_i,
    // Serial port
    input wire logic       sclk_i,
    input wire logic       csn_i,
    input wire logic       sdio_out_o,
    input wire logic       sdio_oe_o,
    input wire logic       dedicated_read_output_pin_o,
    input wire logic       dedicated_read_output_pin_oe_o,
    // Active settings
    input wire logic [7:0] pd_sync_active_o,
    input wire logic       soft_reset_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Three samples high: any change launched by the last fall has landed
    sequence sclk_held;
        (sclk_i && !csn_i)[*3];
    endsequence
    sequence csn_idle;
        csn_i[*2];
    endsequence
    one_driver_a: assert property (!(sdio_oe_o && dedicated_read_output_pin_oe_o))
        else $error("both data pins driven");
    idle_release_a: assert property (csn_idle |-> !sdio_oe_o && !dedicated_read_output_pin_oe_o)
        else $error("pin driven outside frame");
    frame_drive_a: assert property (sdio_oe_o || dedicated_read_output_pin_oe_o |-> !$past(csn_i))
        else $error("pin driven without select");
    bit_hold_a: assert property (sclk_held |-> $stable(sdio_out_o) && $stable(dedicated_read_output_pin_o))
        else $error("read bit moved while clock high");
    reset_values_a: assert property ($rose(resetn_i) |-> pd_sync_active_o == 8'h00 && !soft_reset_o)
        else $error("bad value after reset");
    srst_hold_a: assert property (soft_reset_o && $past(soft_reset_o) |-> pd_sync_active_o == 8'h00)
        else $error("active copy not held in soft reset");
    active_in_frame_a: assert property ($changed(pd_sync_active_o) |-> !$past(csn_i))
        else $error("active copy moved outside frame");
    srst_in_frame_a: assert property ($changed(soft_reset_o) |-> !$past(csn_i))
        else $error("soft reset moved outside frame");
endmodule // spc_serial_port_config_regs_checker
bind spc_serial_port_config_regs spc_serial_port_config_regs_checker chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .sclk_i(sclk_i), .csn_i(csn_i), .sdio_out_o(sdio_out_o), .sdio_oe_o(sdio_oe_o),
    .dedicated_read_output_pin_o(dedicated_read_output_pin_o), .soft_reset_o(soft_reset_o),
    .dedicated_read_output_pin_oe_o(dedicated_read_output_pin_oe_o), .pd_sync_active_o(pd_sync_active_o));
`default_nettype wire

// file: spc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
(
    // Clock
    input  wire logic clk_i,
    // Device pins
    input  wire logic sdio_out_i,
    input  wire logic sdio_oe_i,
    input  wire logic rd_pin_i,
    input  wire logic rd_pin_oe_i,
    output var  logic sclk_o,
    output var  logic csn_o,
    output wire logic sdio_o
);
    logic drv_reg;
    logic rel_reg;
    // Released line shows the inverse of the last level, not a stale copy
    assign sdio_o = sdio_oe_i ? sdio_out_i : (rel_reg ? ~drv_reg : drv_reg);
    initial {sclk_o, csn_o, drv_reg, rel_reg} = 4'b0100;
    task automatic frame(input logic rw, input logic [12:0] a, input logic [15:0] wd,
                         input logic lsb, input logic osel, output logic [7:0] rd, input int nb = 1);
        logic [15:0] ins;
        int          b;
        // Length code follows the byte count; bytes go out from the top of wd down, the last one from wd[7:0]
        ins = {rw, 2'(nb - 1), a};
        rd = 8'h00;
        b = 0;
        @(negedge clk_i) csn_o = 1'b0;
        for (int i = 0; i < 16 + 8 * nb; i++)
        begin
            @(negedge clk_i) sclk_o = 1'b0;
            rel_reg = rw && i >= 16;
            if (i >= 16)
                b = lsb ? (i - 16) % 8 : 7 - (i - 16) % 8;
            drv_reg = i < 16 ? ins[lsb ? i : 15 - i] : wd[8 * (nb - 1 - (i - 16) / 8) + b];
            repeat (4) @(negedge clk_i);
            // Undriven pin reads as z so a wrong pin never passes
            if (rel_reg)
                rd[b] = osel ? (rd_pin_oe_i && !sdio_oe_i ? rd_pin_i : 1'bz)
                             : (sdio_oe_i && !rd_pin_oe_i ? sdio_out_i : 1'bz);
            sclk_o = 1'b1;
            repeat (3) @(negedge clk_i);
        end
        csn_o = 1'b1;
        rel_reg = 1'b0;
        repeat (2) @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule // spc_host_model
`default_nettype wire

// file: spc_serial_port_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.vh"
module spc_serial_port_config_regs_test;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    wire        sclk, csn, sdio, dedicated_read_output_pin, sdo_en, rpin, rpin_en, srst;
    wire  [7:0] act;
    int         failures = 0;
    int         n_checks = 0;
    logic [7:0] rd;
    always #10 clk = ~clk;
    spc_serial_port_config_regs DUT (.clk_i(clk), .resetn_i(resetn), .sclk_i(sclk), .csn_i(csn),
        .sdio_in_i(sdio), .sdio_out_o(dedicated_read_output_pin), .sdio_oe_o(sdo_en), .dedicated_read_output_pin_o(rpin),
        .dedicated_read_output_pin_oe_o(rpin_en), .pd_sync_active_o(act), .soft_reset_o(srst));
    spc_host_model host (.clk_i(clk), .sdio_out_i(dedicated_read_output_pin), .sdio_oe_i(sdo_en), .rd_pin_i(rpin),
        .rd_pin_oe_i(rpin_en), .sclk_o(sclk), .csn_o(csn), .sdio_o(sdio));
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb = 0, input logic osel = 0);
        logic [7:0] x;
        host.frame(1'b0, a, {8'h00, d}, lsb, osel, x);
    endtask
    task automatic rdr(input logic [12:0] a, input logic lsb = 0, input logic osel = 0);
        host.frame(1'b1, a, 16'h0000, lsb, osel, rd);
    endtask
    task automatic t_ids;
        rdr(`SPC_ADDR_CFG);
        check("config", rd, `SPC_CFG_RESET);
        wr(`SPC_ADDR_VARIANT, 8'h00);
        rdr(`SPC_ADDR_VARIANT);
        check("variant", rd, `SPC_VARIANT_ID);
        rdr(13'h0100);
        check("unmapped", rd, 8'h00);
        $display("test ids done");
    endtask
    task automatic t_update;
        wr(`SPC_ADDR_PD_SYNC, 8'hA5);
        check("active early", act, 8'h00);
        rdr(`SPC_ADDR_PD_SYNC);
        check("buffer read", rd, 8'hA5);
        wr(`SPC_ADDR_RB_SEL, 8'h01);
        rdr(`SPC_ADDR_PD_SYNC);
        check("active read", rd, 8'h00);
        wr(`SPC_ADDR_UPDATE, 8'h01);
        check("active copied", act, 8'hA5);
        rdr(`SPC_ADDR_UPDATE);
        check("update clear", rd, 8'h00);
        $display("test update done");
    endtask
    task automatic t_soft_reset;
        wr(`SPC_ADDR_CFG, 8'h3C);
        check("soft reset on", {7'h00, srst}, 8'h01);
        check("active held", act, 8'h00);
        wr(`SPC_ADDR_PD_SYNC, 8'h77);
        wr(`SPC_ADDR_CFG, 8'h18);
        check("soft reset off", {7'h00, srst}, 8'h00);
        rdr(`SPC_ADDR_PD_SYNC);
        check("buffer default", rd, 8'h00);
        rdr(`SPC_ADDR_RB_SEL);
        check("bank default", rd, 8'h00);
        $display("test soft reset done");
    endtask
    task automatic t_modes;
        wr(`SPC_ADDR_CFG, 8'h5A);
        wr(`SPC_ADDR_PD_SYNC, 8'h2C, 1);
        rdr(`SPC_ADDR_PD_SYNC, 1);
        check("lsb shared pin", rd, 8'h2C);
        wr(`SPC_ADDR_CFG, 8'hDB, 1);
        rdr(`SPC_ADDR_PD_SYNC, 1, 1);
        check("lsb own pin", rd, 8'h2C);
        wr(`SPC_ADDR_CFG, 8'h18, 1, 1);
        rdr(`SPC_ADDR_CFG);
        check("back to msb", rd, 8'h18);
        $display("test modes done");
    endtask
    task automatic t_burst;
        logic [7:0] x;
        // Two bytes from 0x231 downwards; only the second one lands, in 0x230
        host.frame(1'b0, `SPC_ADDR_RSVD_SYS, 16'hEE6B, 1'b0, 1'b0, x, 2);
        rdr(`SPC_ADDR_PD_SYNC);
        check("burst down", rd, 8'h6B);
        rdr(`SPC_ADDR_RSVD_SYS);
        check("reserved", rd, 8'h00);
        wr(`SPC_ADDR_CFG, 8'h5A);
        // Two bytes from 0x22F upwards; only the second one lands, in 0x230
        host.frame(1'b0, 13'h022F, 16'h1194, 1'b1, 1'b0, x, 2);
        rdr(`SPC_ADDR_PD_SYNC, 1);
        check("burst up", rd, 8'h94);
        wr(`SPC_ADDR_CFG, 8'h18, 1);
        rdr(`SPC_ADDR_CFG);
        check("burst msb back", rd, 8'h18);
        $display("test burst done");
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        t_ids;
        t_update;
        t_soft_reset;
        t_modes;
        t_burst;
        wrap_up;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        wrap_up;
    end
endmodule // spc_serial_port_config_regs_test
`default_nettype wire
